//--- design/dbg_ctl_end.sv
// Debug controller end: halt, resume, permissions and static inputs set over Avalon-MM.
// Assumes at most eight processors, one bit each in every byte lane.
//
// Decided for this implementation: the Avalon-MM register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module dbg_ctl_end
  import dbg_hs_pkg::*;
#(
  parameter int NP = NUM_PROC
) (
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              rst_n,
  // Avalon-MM slave
  input  wire logic [CSR_AW-1:0] avs_address,
  input  wire logic              avs_read,
  input  wire logic              avs_write,
  input  wire logic [DATA_W-1:0] avs_writedata,
  output logic [DATA_W-1:0]      avs_readdata,
  output logic                   avs_waitrequest,
  // Link to the processor cluster
  dbg_link_if.ctl                link
);
  import dbg_hs_pkg::*;

  typedef struct packed {
    ctl_state_e [NP-1:0] st;
    logic                ack;
    logic [DATA_W-1:0]   rdata;
    logic [NP-1:0]       inv;
    logic [NP-1:0]       niv;
    logic [NP-1:0]       swa;
    logic [BASE_W-1:0]   base;
    logic                base_v;
    logic [OFF_W-1:0]    off;
    logic                off_v;
  } ctl_s;

  ctl_s q;
  ctl_s next_q;
  logic wr_now;
  logic [NP-1:0] busy;
  logic [NP-1:0] halting;
  logic [NP-1:0] resuming;

  function automatic logic [DATA_W-1:0] lanes(input logic [NP-1:0] a, input logic [NP-1:0] b,
                                              input logic [NP-1:0] c, input logic [NP-1:0] d);
    logic [DATA_W-1:0] r;
    r = '0;
    r[LANE_A +: NP] = a;
    r[LANE_B +: NP] = b;
    r[LANE_C +: NP] = c;
    r[LANE_D +: NP] = d;
    return r;
  endfunction

  always_comb begin
    for (int i = 0; i < NP; i++) begin
      halting[i]  = (q.st[i] == CTL_HALT);
      resuming[i] = (q.st[i] == CTL_RESUME);
    end
    busy = halting | resuming;
  end

  assign wr_now = avs_write & q.ack;

  always_comb begin
    next_q     = q;
    next_q.ack = RST_LOW;
    if ((avs_read || avs_write) && !q.ack) begin
      next_q.ack = 1'b1;
      case (avs_address)
        REG_CMD:    next_q.rdata = lanes(halting, resuming, '0, busy);
        REG_STATUS: next_q.rdata = lanes(link.halt_acknowledge, link.halt_mem_drained,
                                         link.resume_acknowledge, '0);
        REG_ENABLE: next_q.rdata = lanes(q.inv, q.niv, q.swa, '0);
        REG_BASE:   next_q.rdata = {q.base, {(BASE_LSB - 1){1'b0}}, q.base_v};
        REG_OFFSET: next_q.rdata = {q.off, {(OFF_LSB - 1){1'b0}}, q.off_v};
        REG_FLAGS:  next_q.rdata = lanes(link.keep_powered_hint, link.comm_rx_full,
                                         link.comm_tx_full, '0);
        default:    next_q.rdata = '0;
      endcase
    end
    if (wr_now) begin
      case (avs_address)
        REG_ENABLE: begin
          next_q.inv = avs_writedata[LANE_A +: NP];
          next_q.niv = avs_writedata[LANE_B +: NP];
          next_q.swa = avs_writedata[LANE_C +: NP];
        end
        REG_BASE: begin
          next_q.base   = avs_writedata[BASE_LSB +: BASE_W];
          next_q.base_v = avs_writedata[VALID_BIT]; // R14
        end
        REG_OFFSET: begin
          next_q.off   = avs_writedata[OFF_LSB +: OFF_W];
          next_q.off_v = avs_writedata[VALID_BIT]; // R16
        end
        default: begin
        end
      endcase
    end
    for (int i = 0; i < NP; i++) begin
      case (q.st[i])
        CTL_IDLE: begin
          if (wr_now && avs_address == REG_CMD && avs_writedata[LANE_A + i]) begin
            next_q.st[i] = CTL_HALT;
          end else if (wr_now && avs_address == REG_CMD && avs_writedata[LANE_B + i]) begin
            next_q.st[i] = CTL_RESUME;
          end
        end
        // Request is held with no timeout until the processor answers
        CTL_HALT: begin
          if (link.halt_acknowledge[i]) begin // R4
            next_q.st[i] = CTL_IDLE;
          end
        end
        CTL_RESUME: begin
          if (!link.resume_acknowledge[i]) begin // R8
            next_q.st[i] = CTL_IDLE;
          end
        end
        default: begin
          next_q.st[i] = CTL_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  assign avs_waitrequest                 = (avs_read | avs_write) & ~q.ack;
  assign avs_readdata                    = q.rdata;
  assign link.ext_halt_request           = halting;
  assign link.resume_request             = resuming;
  assign link.invasive_dbg_allow         = q.inv;
  assign link.noninvasive_dbg_allow      = q.niv;
  assign link.sw_dbg_access_allow        = q.swa;
  assign link.component_table_base       = q.base;
  assign link.component_table_base_valid = q.base_v;
  assign link.self_register_offset       = q.off;
  assign link.self_register_offset_valid = q.off_v;
endmodule
`default_nettype wire

//--- design/dbg_device_end.sv
// Processor-cluster end of the debug handshake, one lane per processor.
// Assumes the core reports pending pre-halt accesses and routes register traffic here.
// Summary of operation
// R1: Per-processor invasive debug permission input.
// R2: Per-processor noninvasive debug permission input.
// R3: Halt request is sampled as a level.
// R4: Controller holds halt request until acknowledged.
// R5: Halt acknowledge rises on debug entry.
// R6: Drained only in debug, accesses complete.
// R7: Resume request leaves debug state.
// R8: Controller holds resume until acknowledge drops.
// R9: Resume acknowledge sequences the exit handshake.
// R10: Power hint mirrors control register bit zero.
// R11: Software access off: only external writes.
// R12: Software access on: all sources accepted.
// R13: Component table base bits from static input.
// R14: Base valid driven high only when known.
// R15: Static signed offset locates debug registers.
// R16: Offset valid driven high only when known.
// R17: Receive flag shows unread receive data.
// R18: Transmit flag shows full transmit register.
// R19: Bit i of each vector serves processor i.
// R20: Without invasive permission, halt is ignored.
`timescale 1ns/1ps
`default_nettype none
module dbg_device_end
  import dbg_hs_pkg::*;
#(
  parameter int NP = NUM_PROC
) (
  // Clock and reset
  input  wire logic                      clk,
  input  wire logic                      rst_n,
  // Link to the external debug controller
  dbg_link_if.dev                        link,
  // Core state
  input  wire logic [NP-1:0]             mem_pending,
  output logic [NP-1:0]                  debug_state,
  output logic [NP-1:0]                  trace_enable,
  // Power-down control register writes
  input  wire logic [NP-1:0]             pcr_wr,
  input  wire logic [NP-1:0]             pcr_wr_ext,
  input  wire logic [NP-1:0]             pcr_wdata,
  output logic [NP-1:0]                  pcr_wr_denied,
  // Receive channel
  input  wire logic [NP-1:0]             rx_push,
  input  wire logic [NP-1:0][DATA_W-1:0] rx_push_data,
  input  wire logic [NP-1:0]             rx_pop,
  output logic [NP-1:0][DATA_W-1:0]      rx_data,
  // Transmit channel
  input  wire logic [NP-1:0]             tx_push,
  input  wire logic [NP-1:0][DATA_W-1:0] tx_push_data,
  input  wire logic [NP-1:0]             tx_pop,
  output logic [NP-1:0][DATA_W-1:0]      tx_data,
  // Memory-mapped debug register location
  output logic [ADDR_W-1:0]              dbg_regs_addr,
  output logic                           dbg_regs_addr_valid
);
  import dbg_hs_pkg::*;

  typedef struct packed {
    dev_state_e [NP-1:0] st;
    logic [NP-1:0]       halt_ack;
    logic [NP-1:0]       drained;
    logic [NP-1:0]       resume_ack;
    logic [NP-1:0]       trace_en;
    logic [ADDR_W-1:0]   addr;
    logic                addr_valid;
  } dev_s;

  dev_s q;
  dev_s next_q;

  logic [NP-1:0] pcr_bit;
  logic [NP-1:0] rx_full;
  logic [NP-1:0] tx_full;

  always_comb begin
    next_q = q;
    for (int i = 0; i < NP; i++) begin // R19
      next_q.trace_en[i] = link.noninvasive_dbg_allow[i]; // R2
      case (q.st[i])
        DEV_RUN: begin
          next_q.drained[i] = RST_LOW;
          // Level sampled every cycle; a request without permission just waits
          if (link.ext_halt_request[i] && link.invasive_dbg_allow[i]) begin // R1 R3 R20
            next_q.st[i]       = DEV_DEBUG;
            next_q.halt_ack[i] = 1'b1; // R5
          end
        end
        DEV_DEBUG: begin
          next_q.drained[i] = ~mem_pending[i]; // R6
          if (link.resume_request[i]) begin // R7
            next_q.st[i]         = DEV_RESUME;
            next_q.halt_ack[i]   = RST_LOW;
            next_q.drained[i]    = RST_LOW;
            next_q.resume_ack[i] = RST_LOW; // R9
          end
        end
        DEV_RESUME: begin
          // Acknowledge rises only after the request is dropped, closing the handshake
          if (!link.resume_request[i]) begin // R8 R9
            next_q.st[i]         = DEV_RUN;
            next_q.resume_ack[i] = 1'b1;
          end
        end
        default: begin
          next_q.st[i] = DEV_RUN;
        end
      endcase
    end
    // Offset is signed; the 32-bit sum wraps as two's complement
    next_q.addr = {link.component_table_base, {BASE_LSB{1'b0}}}
                + {link.self_register_offset, {OFF_LSB{1'b0}}}; // R13 R15
    next_q.addr_valid = link.component_table_base_valid & link.self_register_offset_valid; // R14 R16
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      q            <= '0;
      q.resume_ack <= {NP{RST_RESUME_ACK}};
    end else begin
      q <= next_q;
    end
  end

  genvar g;
  generate
    for (g = 0; g < NP; g++) begin : g_cell
      dbg_proc_cell u_cell (
        .clk          (clk),
        .rst_n        (rst_n),
        .sw_allow     (link.sw_dbg_access_allow[g]),
        .pcr_wr       (pcr_wr[g]),
        .pcr_wr_ext   (pcr_wr_ext[g]),
        .pcr_wdata    (pcr_wdata[g]),
        .pcr_bit      (pcr_bit[g]),
        .pcr_wr_denied(pcr_wr_denied[g]),
        .rx_push      (rx_push[g]),
        .rx_push_data (rx_push_data[g]),
        .rx_pop       (rx_pop[g]),
        .rx_data      (rx_data[g]),
        .rx_full      (rx_full[g]),
        .tx_push      (tx_push[g]),
        .tx_push_data (tx_push_data[g]),
        .tx_pop       (tx_pop[g]),
        .tx_data      (tx_data[g]),
        .tx_full      (tx_full[g])
      );
    end
  endgenerate

  assign link.halt_acknowledge   = q.halt_ack;
  assign link.halt_mem_drained   = q.drained;
  assign link.resume_acknowledge = q.resume_ack;
  assign link.keep_powered_hint  = pcr_bit; // R10
  assign link.comm_rx_full       = rx_full; // R17
  assign link.comm_tx_full       = tx_full; // R18

  always_comb begin
    for (int i = 0; i < NP; i++) begin
      debug_state[i] = (q.st[i] == DEV_DEBUG);
    end
  end

  assign trace_enable        = q.trace_en;
  assign dbg_regs_addr       = q.addr;
  assign dbg_regs_addr_valid = q.addr_valid;
endmodule
`default_nettype wire

//--- design/dbg_hs_pkg.sv
// Constants and state types of the per-processor debug handshake.
// Assumes one core clock and a synchronous active-low reset.
package dbg_hs_pkg;

  // Processor count and widths
  localparam int NUM_PROC = 2;
  localparam int MAX_PROC = 8;
  localparam int DATA_W   = 32;
  localparam int ADDR_W   = 32;
  localparam int BASE_LSB = 12;
  localparam int BASE_W   = ADDR_W - BASE_LSB;
  localparam int OFF_LSB  = 17;
  localparam int OFF_W    = ADDR_W - OFF_LSB;

  // Controller register word addresses
  localparam int          CSR_AW     = 3;
  localparam logic [2:0]  REG_CMD    = 3'h0;
  localparam logic [2:0]  REG_STATUS = 3'h1;
  localparam logic [2:0]  REG_ENABLE = 3'h2;
  localparam logic [2:0]  REG_BASE   = 3'h3;
  localparam logic [2:0]  REG_OFFSET = 3'h4;
  localparam logic [2:0]  REG_FLAGS  = 3'h5;

  // Byte lanes per register word, valid bit position
  localparam int LANE_A    = 0;
  localparam int LANE_B    = 8;
  localparam int LANE_C    = 16;
  localparam int LANE_D    = 24;
  localparam int VALID_BIT = 0;

  // Values after reset
  localparam logic RST_RESUME_ACK = 1'b1;
  localparam logic RST_LOW        = 1'b0;

  typedef enum logic [1:0] {DEV_RUN, DEV_DEBUG, DEV_RESUME} dev_state_e;
  typedef enum logic [1:0] {CTL_IDLE, CTL_HALT, CTL_RESUME} ctl_state_e;

endpackage

//--- design/dbg_link_if.sv
// Link between the cluster debug boundary and its debug controller.
// Assumes one shared core clock; all signals are levels.
`timescale 1ns/1ps
`default_nettype none
interface dbg_link_if #(
  parameter int NP = dbg_hs_pkg::NUM_PROC
) ();
  logic [NP-1:0]                 invasive_dbg_allow;
  logic [NP-1:0]                 noninvasive_dbg_allow;
  logic [NP-1:0]                 ext_halt_request;
  logic [NP-1:0]                 halt_acknowledge;
  logic [NP-1:0]                 halt_mem_drained;
  logic [NP-1:0]                 resume_request;
  logic [NP-1:0]                 resume_acknowledge;
  logic [NP-1:0]                 keep_powered_hint;
  logic [NP-1:0]                 sw_dbg_access_allow;
  logic [dbg_hs_pkg::BASE_W-1:0] component_table_base;
  logic                          component_table_base_valid;
  logic [dbg_hs_pkg::OFF_W-1:0]  self_register_offset;
  logic                          self_register_offset_valid;
  logic [NP-1:0]                 comm_rx_full;
  logic [NP-1:0]                 comm_tx_full;

  modport dev (
    input  invasive_dbg_allow, noninvasive_dbg_allow, ext_halt_request, resume_request,
    input  sw_dbg_access_allow, component_table_base, component_table_base_valid,
    input  self_register_offset, self_register_offset_valid,
    output halt_acknowledge, halt_mem_drained, resume_acknowledge, keep_powered_hint,
    output comm_rx_full, comm_tx_full
  );

  modport ctl (
    output invasive_dbg_allow, noninvasive_dbg_allow, ext_halt_request, resume_request,
    output sw_dbg_access_allow, component_table_base, component_table_base_valid,
    output self_register_offset, self_register_offset_valid,
    input  halt_acknowledge, halt_mem_drained, resume_acknowledge, keep_powered_hint,
    input  comm_rx_full, comm_tx_full
  );
endinterface
`default_nettype wire

//--- design/dbg_proc_cell.sv
// One processor's power-down control bit and channel registers.
// Assumes the device end routes this processor's accesses here.
`timescale 1ns/1ps
`default_nettype none
module dbg_proc_cell
  import dbg_hs_pkg::*;
(
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              rst_n,
  // Access permission
  input  wire logic              sw_allow,
  // Power-down control register write
  input  wire logic              pcr_wr,
  input  wire logic              pcr_wr_ext,
  input  wire logic              pcr_wdata,
  output logic                   pcr_bit,
  output logic                   pcr_wr_denied,
  // Receive channel: external side fills, core drains
  input  wire logic              rx_push,
  input  wire logic [DATA_W-1:0] rx_push_data,
  input  wire logic              rx_pop,
  output logic [DATA_W-1:0]      rx_data,
  output logic                   rx_full,
  // Transmit channel: core fills, external side drains
  input  wire logic              tx_push,
  input  wire logic [DATA_W-1:0] tx_push_data,
  input  wire logic              tx_pop,
  output logic [DATA_W-1:0]      tx_data,
  output logic                   tx_full
);
  import dbg_hs_pkg::*;

  typedef struct packed {
    logic              pcr;
    logic              denied;
    logic              rx_full;
    logic              tx_full;
    logic [DATA_W-1:0] rx_data;
    logic [DATA_W-1:0] tx_data;
  } cell_s;

  cell_s q;
  cell_s next_q;

  always_comb begin
    next_q = q;
    // Writes from anything but the external agent are refused while software access is off
    next_q.denied = pcr_wr & ~pcr_wr_ext & ~sw_allow; // R11
    if (pcr_wr && (pcr_wr_ext || sw_allow)) begin // R11 R12
      next_q.pcr = pcr_wdata;
    end
    // A push in the cycle of a pop wins, so no word is lost
    if (rx_pop) begin
      next_q.rx_full = RST_LOW;
    end
    if (rx_push && (!q.rx_full || rx_pop)) begin // R17
      next_q.rx_full = 1'b1;
      next_q.rx_data = rx_push_data;
    end
    if (tx_pop) begin
      next_q.tx_full = RST_LOW;
    end
    if (tx_push && (!q.tx_full || tx_pop)) begin // R18
      next_q.tx_full = 1'b1;
      next_q.tx_data = tx_push_data;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  assign pcr_bit       = q.pcr;
  assign pcr_wr_denied = q.denied;
  assign rx_full       = q.rx_full;
  assign rx_data       = q.rx_data;
  assign tx_full       = q.tx_full;
  assign tx_data       = q.tx_data;
endmodule
`default_nettype wire

//--- verification/dbg_link_checker.sv
// Checker of the halt and resume handshakes on one link between the two ends.
// Assumes the link signals as plain inputs, sampled on the core clock.
`timescale 1ns/1ps
`default_nettype none
module dbg_link_checker #(
  parameter int NP = 2
) (
  input wire logic          clk,
  input wire logic          rst_n,
  input wire logic [NP-1:0] invasive_dbg_allow,
  input wire logic [NP-1:0] ext_halt_request,
  input wire logic [NP-1:0] halt_acknowledge,
  input wire logic [NP-1:0] halt_mem_drained,
  input wire logic [NP-1:0] resume_request,
  input wire logic [NP-1:0] resume_acknowledge
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  for (genvar i = 0; i < NP; i++) begin : g_proc
    // Halt acknowledge low with resume acknowledge high means running
    sequence s_halt_taken;
      invasive_dbg_allow[i] && ext_halt_request[i] && !halt_acknowledge[i] && resume_acknowledge[i];
    endsequence
    sequence s_resume_seen;
      resume_request[i] && halt_acknowledge[i];
    endsequence
    sequence s_left_debug;
      !halt_acknowledge[i] && !resume_acknowledge[i] && resume_request[i];
    endsequence
    AST_HALT_TAKEN: assert property (s_halt_taken |=> halt_acknowledge[i])
      else $error("halt request not acknowledged");
    AST_ACK_CAUSE: assert property ($rose(halt_acknowledge[i]) |-> $past(invasive_dbg_allow[i]) && $past(ext_halt_request[i]))
      else $error("acknowledge without permitted request");
    AST_NO_ALLOW: assert property (!invasive_dbg_allow[i] && !halt_acknowledge[i] |=> !halt_acknowledge[i])
      else $error("halt entered without permission");
    AST_DRAINED: assert property (halt_mem_drained[i] |-> halt_acknowledge[i])
      else $error("drained outside debug state");
    AST_HALT_HELD: assert property (ext_halt_request[i] && !halt_acknowledge[i] |=> ext_halt_request[i])
      else $error("halt request dropped early");
    AST_HALT_DROP: assert property ($rose(halt_acknowledge[i]) |=> !ext_halt_request[i])
      else $error("halt request kept after acknowledge");
    AST_RESUME_EXIT: assert property (s_resume_seen |=> s_left_debug)
      else $error("resume not taken");
    AST_RESUME_DONE: assert property (s_resume_seen ##1 s_left_debug |=> !resume_request[i] ##1 resume_acknowledge[i])
      else $error("resume handshake not closed");
    AST_RACK_LOW: assert property (!resume_acknowledge[i] && resume_request[i] |=> !resume_acknowledge[i])
      else $error("resume acknowledge back too early");
  end
endmodule
`default_nettype wire

//--- verification/testbench.sv
// Bench: controller and device ends on one link, plus a device end on a bench-driven link.
// Assumes a 10 MHz core clock.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import dbg_hs_pkg::*;
  localparam int NP    = NUM_PROC;
  localparam int LIMIT = 5000;
  logic                clk           = 1'b0;
  logic                rst_n         = 1'b0;
  logic [CSR_AW-1:0]   avs_address   = '0;
  logic                avs_read      = 1'b0;
  logic                avs_write     = 1'b0;
  logic [DATA_W-1:0]   avs_writedata = '0;
  logic [DATA_W-1:0]   avs_readdata;
  logic                avs_waitrequest;
  logic [NP-1:0]       mem_pending   = '0;
  logic [NP-1:0]       debug_state;
  logic [NP-1:0]       trace_enable;
  logic [NP-1:0]       pcr_wr        = '0;
  logic [NP-1:0]       pcr_wr_ext    = '0;
  logic [NP-1:0]       pcr_wdata     = '0;
  logic [NP-1:0]       pcr_wr_denied;
  logic [NP-1:0]       rx_push       = '0;
  logic [NP-1:0]       rx_pop        = '0;
  logic [NP-1:0]       tx_push       = '0;
  logic [NP-1:0]       tx_pop        = '0;
  logic [NP-1:0][31:0] rx_push_data  = '0;
  logic [NP-1:0][31:0] tx_push_data  = '0;
  logic [NP-1:0][31:0] rx_data;
  logic [NP-1:0][31:0] tx_data;
  logic [ADDR_W-1:0]   dbg_regs_addr;
  logic                dbg_regs_addr_valid;
  logic [31:0]         rd;
  int                  miscompares   = 0;
  int                  total_checks  = 0;
  int                  cycles        = 0;

  dbg_link_if #(.NP(NP)) link ();
  dbg_link_if #(.NP(NP)) link2 ();

  dbg_ctl_end #(.NP(NP)) dbg_ctl_end_inst (.clk(clk), .rst_n(rst_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .link(link.ctl));

  dbg_device_end #(.NP(NP)) dbg_device_end_inst (.clk(clk), .rst_n(rst_n), .link(link.dev),
    .mem_pending(mem_pending), .debug_state(debug_state), .trace_enable(trace_enable),
    .pcr_wr(pcr_wr), .pcr_wr_ext(pcr_wr_ext), .pcr_wdata(pcr_wdata), .pcr_wr_denied(pcr_wr_denied),
    .rx_push(rx_push), .rx_push_data(rx_push_data), .rx_pop(rx_pop), .rx_data(rx_data),
    .tx_push(tx_push), .tx_push_data(tx_push_data), .tx_pop(tx_pop), .tx_data(tx_data),
    .dbg_regs_addr(dbg_regs_addr), .dbg_regs_addr_valid(dbg_regs_addr_valid));

  // Bench-driven link breaks the controller's rules
  dbg_device_end #(.NP(NP)) dbg_device_end_inst2 (.clk(clk), .rst_n(rst_n), .link(link2.dev),
    .mem_pending(mem_pending), .debug_state(), .trace_enable(), .pcr_wr(pcr_wr),
    .pcr_wr_ext(pcr_wr_ext), .pcr_wdata(pcr_wdata), .pcr_wr_denied(), .rx_push(rx_push),
    .rx_push_data(rx_push_data), .rx_pop(rx_pop), .rx_data(), .tx_push(tx_push),
    .tx_push_data(tx_push_data), .tx_pop(tx_pop), .tx_data(), .dbg_regs_addr(), .dbg_regs_addr_valid());

  dbg_link_checker #(.NP(NP)) dbg_link_checker_inst (.clk(clk), .rst_n(rst_n),
    .invasive_dbg_allow(link.invasive_dbg_allow), .ext_halt_request(link.ext_halt_request),
    .halt_acknowledge(link.halt_acknowledge), .halt_mem_drained(link.halt_mem_drained),
    .resume_request(link.resume_request), .resume_acknowledge(link.resume_acknowledge));

  always #50 clk = ~clk;

  initial begin
    link2.invasive_dbg_allow = '0;
    link2.noninvasive_dbg_allow = '0;
    link2.ext_halt_request = '0;
    link2.resume_request = '0;
    link2.sw_dbg_access_allow = '0;
    link2.component_table_base = '0;
    link2.component_table_base_valid = 1'b0;
    link2.self_register_offset = '0;
    link2.self_register_offset_valid = 1'b0;
  end

  task automatic stop_test();
    $display("Checks %0d, mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      miscompares++;
      stop_test();
    end
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Request held until the rising edge that samples waitrequest low
  task automatic avs(input logic wr, input logic [2:0] adr, input logic [31:0] wd, output logic [31:0] r);
    @(posedge clk);
    avs_address <= adr;
    avs_writedata <= wd;
    avs_write <= wr;
    avs_read <= !wr;
    do begin
      @(posedge clk);
    end while (avs_waitrequest !== 1'b0);
    r = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask

  task automatic wr(input logic [2:0] adr, input logic [31:0] d);
    logic [31:0] r;
    avs(1'b1, adr, d, r);
  endtask

  task automatic wait_lvl(input bit rack, input int i, input logic v);
    for (int n = 0; n < 20; n++) begin
      if ((rack ? link.resume_acknowledge[i] : link.halt_acknowledge[i]) === v) break;
      @(negedge clk);
    end
  endtask

  task automatic t_reset();
    @(negedge clk);
    check("halt_ack", link.halt_acknowledge, 2'b00);
    check("resume_ack", link.resume_acknowledge, 2'b11);
    check("keep_powered", link.keep_powered_hint, 2'b00);
    avs(1'b0, REG_STATUS, 32'h0, rd);
    check("status", rd, 32'h0003_0000);
  endtask

  task automatic t_config();
    wr(REG_ENABLE, 32'h0000_0201);
    avs(1'b0, REG_ENABLE, 32'h0, rd);
    check("enable", rd, 32'h0000_0201);
    wr(REG_BASE, 32'h1234_5001);
    wr(REG_OFFSET, 32'hfffe_0001);
    repeat (3) @(negedge clk);
    check("invasive", link.invasive_dbg_allow, 2'b01);
    check("trace_enable", trace_enable, 2'b10);
    check("base", link.component_table_base, 20'h12345);
    check("regs_addr", dbg_regs_addr, 32'h1232_5000);
    check("addr_valid", dbg_regs_addr_valid, 1'b1);
    wr(REG_OFFSET, 32'hfffe_0000);
    repeat (3) @(negedge clk);
    check("addr_valid", dbg_regs_addr_valid, 1'b0);
    avs(1'b0, 3'h7, 32'h0, rd);
    check("unmapped", rd, 32'h0);
  endtask

  task automatic pcr_op(input logic [1:0] m, ext, d, deny, hint);
    @(posedge clk);
    pcr_wr <= m;
    pcr_wr_ext <= ext;
    pcr_wdata <= d;
    @(posedge clk);
    pcr_wr <= 2'b00;
    @(negedge clk);
    check("pcr_denied", pcr_wr_denied, deny);
    @(negedge clk);
    check("keep_powered", link.keep_powered_hint, hint);
  endtask

  task automatic t_pcr();
    pcr_op(2'b01, 2'b00, 2'b01, 2'b01, 2'b00);
    pcr_op(2'b01, 2'b01, 2'b01, 2'b00, 2'b01);
    wr(REG_ENABLE, 32'h0001_0201);
    pcr_op(2'b11, 2'b00, 2'b10, 2'b10, 2'b00);
    pcr_op(2'b01, 2'b00, 2'b01, 2'b00, 2'b01);
  endtask

  task automatic t_chan();
    @(posedge clk);
    rx_push <= 2'b01;
    rx_push_data[0] <= 32'hcafe_0001;
    @(posedge clk);
    rx_push <= 2'b00;
    rx_pop <= 2'b01;
    @(negedge clk);
    check("rx_full", link.comm_rx_full, 2'b01);
    check("rx_data", rx_data[0], 32'hcafe_0001);
    @(posedge clk);
    rx_pop <= 2'b00;
    tx_push <= 2'b10;
    tx_push_data[1] <= 32'h0000_beef;
    @(negedge clk);
    check("rx_full", link.comm_rx_full, 2'b00);
    @(posedge clk);
    tx_push_data[1] <= 32'h1111_2222;
    @(posedge clk);
    tx_push <= 2'b00;
    @(negedge clk);
    check("tx_full", link.comm_tx_full, 2'b10);
    check("tx_data", tx_data[1], 32'h0000_beef);
    avs(1'b0, REG_FLAGS, 32'h0, rd);
    check("flags", rd, 32'h0002_0001);
  endtask

  task automatic t_halt();
    @(posedge clk);
    mem_pending <= 2'b01;
    wr(REG_CMD, 32'h0000_0003);
    wait_lvl(1'b0, 0, 1'b1);
    check("halt_ack", link.halt_acknowledge, 2'b01);
    check("debug_state", debug_state, 2'b01);
    check("drained", link.halt_mem_drained, 2'b00);
    check("halt_req1", link.ext_halt_request[1], 1'b1);
    @(posedge clk);
    mem_pending <= 2'b00;
    repeat (2) @(negedge clk);
    check("drained", link.halt_mem_drained, 2'b01);
    avs(1'b0, REG_STATUS, 32'h0, rd);
    check("status", rd, 32'h0003_0101);
    avs(1'b0, REG_CMD, 32'h0, rd);
    check("cmd", rd, 32'h0200_0002);
    wr(REG_CMD, 32'h0000_0100);
    wait_lvl(1'b1, 0, 1'b0);
    check("halt_ack", link.halt_acknowledge, 2'b00);
    check("debug_state", debug_state, 2'b00);
    wait_lvl(1'b1, 0, 1'b1);
    check("resume_req", link.resume_request, 2'b00);
    wr(REG_ENABLE, 32'h0001_0203);
    wait_lvl(1'b0, 1, 1'b1);
    check("halt_ack", link.halt_acknowledge, 2'b10);
    wr(REG_CMD, 32'h0000_0200);
    wait_lvl(1'b1, 1, 1'b0);
    wait_lvl(1'b1, 1, 1'b1);
    check("resume_ack", link.resume_acknowledge, 2'b11);
  endtask

  task automatic t_fault();
    @(posedge clk);
    link2.ext_halt_request <= 2'b01;
    repeat (3) @(posedge clk);
    link2.ext_halt_request <= 2'b00;
    @(posedge clk);
    link2.invasive_dbg_allow <= 2'b01;
    repeat (3) @(negedge clk);
    check("fault_ack", link2.halt_acknowledge, 2'b00);
    @(posedge clk);
    link2.ext_halt_request <= 2'b01;
    repeat (2) @(negedge clk);
    check("fault_ack", link2.halt_acknowledge, 2'b01);
    @(posedge clk);
    link2.ext_halt_request <= 2'b00;
  endtask

  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_config();
    t_pcr();
    t_chan();
    t_halt();
    t_fault();
    stop_test();
  end
endmodule
`default_nettype wire
